//--- inc/gain_offset_pkg.sv
// Shared register map, field layout, limits and timing counts for the gain/offset block
package gain_offset_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_GAIN = 12'h004;
  localparam logic [11:0] ADDR_RAW = 12'h008;
  localparam logic [11:0] ADDR_OFFSET = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_SENSOR = 12'h014;
  // Control register fields and the digital gain field of the sensor register
  localparam int CTRL_STAGE_LSB = 0;
  localparam int CTRL_CHAN_BIT = 2;
  localparam int CTRL_OVERLAP_BIT = 3;
  localparam int CTRL_FPN_BIT = 4;
  localparam int CTRL_FAMILY_BIT = 5;
  localparam int SENSOR_DIG_LSB = 16;
  // Gain stage codes
  localparam logic [1:0] STAGE_SENSOR_ALL = 2'h0;
  localparam logic [1:0] STAGE_SENSOR_ANALOG = 2'h1;
  localparam logic [1:0] STAGE_SENSOR_DIGITAL = 2'h2;
  localparam logic [1:0] STAGE_DIGITAL_ALL = 2'h3;
  // Gains in hundredths, post gain in tenths, raw gain code in 0.1 dB, offsets in DN
  localparam logic [31:0] GAIN_MIN = 32'h0000_0064;
  localparam logic [31:0] A_ALL_MAX = 32'h0000_620c;
  localparam logic [31:0] A_ANALOG_MAX = 32'h0000_0631;
  localparam logic [31:0] B_ANALOG_MAX = 32'h0000_0320;
  localparam logic [31:0] B_DIGITAL_MAX = 32'h0000_0c7f;
  localparam logic [31:0] POST_MIN = 32'h0000_000a;
  localparam logic [31:0] POST_MAX = 32'h0000_0028;
  localparam logic [31:0] RAW_A_MAX = 32'h0000_01e0;
  localparam logic [31:0] OFFSET_A_MAX = 32'h0000_01ff;
  localparam logic [31:0] OFFSET_B_MAX = 32'h0000_00ff;
  // Fixed-point reciprocals (x65536) of 15.85 and of 10
  localparam logic [15:0] RECIP_ANALOG_MAX = 16'h1026;
  localparam logic [15:0] RECIP_TEN = 16'h199a;
  // Reset values
  localparam logic [15:0] GAIN_RESET = 16'h0064;
  localparam logic [5:0] POST_RESET = 6'h0a;
  localparam logic [8:0] OFFSET_RESET = 9'h000;
  localparam logic [8:0] RAW_RESET = 9'h000;
  // Row timing counts in pclk cycles
  localparam int ROW_BLANK_CYC = 8;
  localparam int ROW_READ_CYC = 32;
endpackage

//--- logic/db_gain_lut.sv
// Converts a gain code in 0.1 dB units into a linear gain in hundredths
`timescale 1ns/1ps
module db_gain_lut
  import gain_offset_pkg::*;
(
  // Code in, gain out
  input wire logic [8:0] code,
  output logic [15:0] gain_x100
);
  always_comb
  begin
    logic [8:0] whole_db;
    logic [3:0] frac;
    logic [3:0] octave;
    logic [2:0] step;
    logic [10:0] coarse;
    logic [10:0] fine;
    logic [31:0] lin;
    coarse = 11'h400;
    fine = 11'h400;
    whole_db = code / 9'd10;
    frac = 4'(code % 9'd10);
    // 6 dB is taken as one doubling; error grows with each octave to about 2 % at 48 dB
    octave = 4'(whole_db / 9'd6);
    step = 3'(whole_db % 9'd6);
    case (step)
      3'h0: coarse = 11'h400;
      3'h1: coarse = 11'h47d;
      3'h2: coarse = 11'h509;
      3'h3: coarse = 11'h5a6;
      3'h4: coarse = 11'h657;
      default: coarse = 11'h71d;
    endcase
    case (frac)
      4'h0: fine = 11'h400;
      4'h1: fine = 11'h40c;
      4'h2: fine = 11'h418;
      4'h3: fine = 11'h424;
      4'h4: fine = 11'h430;
      4'h5: fine = 11'h43d;
      4'h6: fine = 11'h449;
      4'h7: fine = 11'h456;
      4'h8: fine = 11'h463;
      default: fine = 11'h470;
    endcase
    lin = ((32'(coarse) * 32'(fine) * 32'h64) >> 20) << octave;
    gain_x100 = (lin > 32'h0000_ffff) ? 16'hffff : lin[15:0];
  end
endmodule

//--- logic/pixel_gain_offset_control.sv
// Gain and dark offset control for the sensor pixel path, with APB registers
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module pixel_gain_offset_control
  import gain_offset_pkg::*;
#(
  parameter int PW = 12,
  parameter int BLANK_CYCLES = ROW_BLANK_CYC,
  parameter int READ_CYCLES = ROW_READ_CYC
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Raw pixels from the sensor receiver
  input wire logic raw_pixel_valid,
  input wire logic [PW-1:0] raw_pixel_data,
  input wire logic row_request,
  // Image path out
  output logic image_valid,
  output logic [PW-1:0] image_data,
  // Sensor control
  output logic [15:0] sensor_analog_gain,
  output logic [15:0] sensor_digital_gain,
  output logic [8:0] sensor_dark_offset,
  output logic overlapped_row_readout,
  output logic fixed_pattern_correction_mode,
  output logic row_blank,
  output logic row_read
);
  typedef enum logic [1:0] {RD_IDLE, RD_BLANK, RD_READ, RD_BOTH} readout_t;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [1:0] stage;
    logic chan;
    logic overlap;
    logic fixed_pattern_noise;
    logic family;
    logic [15:0] g_all;
    logic [15:0] g_ana;
    logic [15:0] g_dig;
    logic [5:0] g_post;
    logic [8:0] raw;
    logic raw_load;
    logic raw_mode;
    logic [8:0] off_sensor;
    logic [8:0] off_digital;
    logic [15:0] out_ana;
    logic [15:0] out_dig;
    readout_t rd;
    logic [15:0] cnt;
    logic blank;
    logic read;
  } ctl_t;
  ctl_t ctl_reg;
  ctl_t ctl_next;
  localparam int OVL_CYCLES = (BLANK_CYCLES > READ_CYCLES) ? BLANK_CYCLES : READ_CYCLES;
  logic [15:0] raw_gain_x100;
  function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [31:0] lo,
                                          input logic [31:0] hi);
    logic [31:0] r;
    r = (v < lo) ? lo : ((v > hi) ? hi : v);
    return r[15:0];
  endfunction
  db_gain_lut u_lut (
    .code(ctl_reg.raw),
    .gain_x100(raw_gain_x100)
  );
  pixel_gain_path #(.PW(PW)) u_path (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(raw_pixel_valid),
    .in_data(raw_pixel_data),
    .gain_x10(ctl_reg.g_post),
    .offset(ctl_reg.off_digital),
    .out_valid(image_valid),
    .out_data(image_data)
  );
  always_comb
  begin
    logic setup;
    logic wr;
    logic [31:0] sel_gain;
    logic [31:0] g;
    logic [31:0] off_max;
    logic [47:0] split;
    sel_gain = 32'h0;
    g = 32'h0;
    split = 48'h0;
    setup = psel && !penable;
    wr = psel && penable && ctl_reg.pready && pwrite;
    ctl_next = ctl_reg;
    ctl_next.raw_load = 1'b0;
    off_max = ctl_reg.family ? OFFSET_B_MAX : OFFSET_A_MAX;
    case (ctl_reg.stage)
      STAGE_SENSOR_ALL: sel_gain = ctl_reg.family ? 32'(ctl_reg.g_ana) : 32'(ctl_reg.g_all);
      STAGE_SENSOR_ANALOG: sel_gain = 32'(ctl_reg.g_ana);
      STAGE_SENSOR_DIGITAL: sel_gain = 32'(ctl_reg.g_dig);
      default: sel_gain = 32'(ctl_reg.g_post);
    endcase
    // Answer in the access cycle right after setup: no wait states
    ctl_next.pready = setup;
    if (setup)
    begin
      ctl_next.pslverr = 1'b0;
      ctl_next.prdata = 32'h0;
      case (paddr)
        ADDR_CTRL:
        begin
          ctl_next.prdata[CTRL_STAGE_LSB +: 2] = ctl_reg.stage;
          ctl_next.prdata[CTRL_CHAN_BIT] = ctl_reg.chan;
          ctl_next.prdata[CTRL_OVERLAP_BIT] = ctl_reg.overlap;
          ctl_next.prdata[CTRL_FPN_BIT] = ctl_reg.fixed_pattern_noise;
          ctl_next.prdata[CTRL_FAMILY_BIT] = ctl_reg.family;
        end
        ADDR_GAIN: ctl_next.prdata = sel_gain;
        // second family reports the stage's raw control
        ADDR_RAW: ctl_next.prdata = ctl_reg.family ? sel_gain : 32'(ctl_reg.raw);
        ADDR_OFFSET:
          ctl_next.prdata = ctl_reg.chan ? 32'(ctl_reg.off_digital) : 32'(ctl_reg.off_sensor);
        ADDR_STATUS:
          ctl_next.prdata = {28'h0, ctl_reg.raw_mode, ctl_reg.read, ctl_reg.blank,
                             ctl_reg.rd != RD_IDLE};
        ADDR_SENSOR: ctl_next.prdata = {ctl_reg.out_dig, ctl_reg.out_ana};
        default: ctl_next.pslverr = 1'b1;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        ADDR_CTRL:
        begin
          ctl_next.stage = pwdata[CTRL_STAGE_LSB +: 2];
          // channel 0 is the sensor dark offset
          ctl_next.chan = pwdata[CTRL_CHAN_BIT];
          ctl_next.overlap = pwdata[CTRL_OVERLAP_BIT];
          ctl_next.fixed_pattern_noise = pwdata[CTRL_FPN_BIT];
          ctl_next.family = pwdata[CTRL_FAMILY_BIT];
        end
        ADDR_GAIN:
        begin
          // write lands on the selected stage
          case (ctl_reg.stage)
            STAGE_SENSOR_ALL:
            begin
              if (ctl_reg.family)
                ctl_next.g_ana = clamp16(pwdata, GAIN_MIN, B_ANALOG_MAX);
              else
              begin
                ctl_next.g_all = clamp16(pwdata, GAIN_MIN, A_ALL_MAX);
                ctl_next.raw_mode = 1'b0;
              end
            end
            STAGE_SENSOR_ANALOG: ctl_next.g_ana = clamp16(pwdata, GAIN_MIN, B_ANALOG_MAX);
            STAGE_SENSOR_DIGITAL: ctl_next.g_dig = clamp16(pwdata, GAIN_MIN, B_DIGITAL_MAX);
            default: ctl_next.g_post = 6'(clamp16(pwdata, POST_MIN, POST_MAX));
          endcase
        end
        ADDR_RAW:
        begin
          // raw code as second way to set gain
          if (ctl_reg.family)
          begin
            // direct write to the selected stage
            case (ctl_reg.stage)
              STAGE_SENSOR_DIGITAL: ctl_next.g_dig = clamp16(pwdata, GAIN_MIN, B_DIGITAL_MAX);
              STAGE_DIGITAL_ALL: ctl_next.g_post = 6'(clamp16(pwdata, POST_MIN, POST_MAX));
              default: ctl_next.g_ana = clamp16(pwdata, GAIN_MIN, B_ANALOG_MAX);
            endcase
          end
          else
          begin
            ctl_next.raw = 9'(clamp16(pwdata, 32'h0, RAW_A_MAX));
            ctl_next.raw_load = 1'b1;
          end
        end
        ADDR_OFFSET:
        begin
          // family one 0..511; family two 0..255
          if (pwdata[CTRL_CHAN_BIT - 2] == 1'b0 && !ctl_reg.chan)
            ctl_next.off_sensor = 9'(clamp16(pwdata, 32'h0, off_max));
          else if (ctl_reg.chan)
            ctl_next.off_digital = 9'(clamp16(pwdata, 32'h0, off_max));
          else
            ctl_next.off_sensor = 9'(clamp16(pwdata, 32'h0, off_max));
        end
        default:
        begin
        end
      endcase
    end
    // Converted raw code takes over the combined sensor gain one cycle later
    if (ctl_reg.raw_load)
    begin
      ctl_next.g_all = clamp16(32'(raw_gain_x100), GAIN_MIN, A_ALL_MAX);
      ctl_next.raw_mode = 1'b1;
    end
    // analog up to 15.85, remainder digital
    if (!ctl_reg.family)
    begin
      g = 32'(clamp16(32'(ctl_reg.g_all), GAIN_MIN, A_ALL_MAX));
      split = (48'(g) * 48'(RECIP_ANALOG_MAX)) >> 16;
      if (g <= A_ANALOG_MAX)
      begin
        ctl_next.out_ana = g[15:0];
        ctl_next.out_dig = GAIN_RESET;
      end
      else
      begin
        ctl_next.out_ana = A_ANALOG_MAX[15:0];
        ctl_next.out_dig = split[15:0];
      end
    end
    else
    begin
      // stale values clamped after a family change
      ctl_next.out_ana = clamp16(32'(ctl_reg.g_ana), GAIN_MIN, B_ANALOG_MAX);
      ctl_next.out_dig = clamp16(32'(ctl_reg.g_dig), GAIN_MIN, B_DIGITAL_MAX);
    end
    // row sequencer; mode is sampled at row start
    case (ctl_reg.rd)
      RD_IDLE:
      begin
        ctl_next.cnt = 16'h0;
        if (row_request)
        begin
          ctl_next.blank = 1'b1;
          ctl_next.read = ctl_reg.overlap;
          ctl_next.rd = ctl_reg.overlap ? RD_BOTH : RD_BLANK;
        end
      end
      RD_BLANK:
      begin
        ctl_next.cnt = ctl_reg.cnt + 16'h1;
        if (ctl_reg.cnt == 16'(BLANK_CYCLES - 1))
        begin
          ctl_next.cnt = 16'h0;
          ctl_next.blank = 1'b0;
          ctl_next.read = 1'b1;
          ctl_next.rd = RD_READ;
        end
      end
      RD_READ:
      begin
        ctl_next.cnt = ctl_reg.cnt + 16'h1;
        if (ctl_reg.cnt == 16'(READ_CYCLES - 1))
        begin
          ctl_next.read = 1'b0;
          ctl_next.rd = RD_IDLE;
        end
      end
      RD_BOTH:
      begin
        ctl_next.cnt = ctl_reg.cnt + 16'h1;
        if (ctl_reg.cnt == 16'(BLANK_CYCLES - 1))
          ctl_next.blank = 1'b0;
        if (ctl_reg.cnt == 16'(READ_CYCLES - 1))
          ctl_next.read = 1'b0;
        if (ctl_reg.cnt == 16'(OVL_CYCLES - 1))
          ctl_next.rd = RD_IDLE;
      end
      default: ctl_next.rd = RD_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_reg <= '0;
      ctl_reg.g_all <= GAIN_RESET;
      ctl_reg.g_ana <= GAIN_RESET;
      ctl_reg.g_dig <= GAIN_RESET;
      ctl_reg.g_post <= POST_RESET;
      ctl_reg.raw <= RAW_RESET;
      ctl_reg.off_sensor <= OFFSET_RESET;
      ctl_reg.off_digital <= OFFSET_RESET;
      ctl_reg.out_ana <= GAIN_RESET;
      ctl_reg.out_dig <= GAIN_RESET;
      ctl_reg.rd <= RD_IDLE;
    end
    else
      ctl_reg <= ctl_next;
  end
  assign pready = ctl_reg.pready;
  assign prdata = ctl_reg.prdata;
  assign pslverr = ctl_reg.pslverr;
  assign sensor_analog_gain = ctl_reg.out_ana;
  assign sensor_digital_gain = ctl_reg.out_dig;
  // analog channel drives the sensor's own offset
  assign sensor_dark_offset = ctl_reg.off_sensor;
  assign overlapped_row_readout = ctl_reg.overlap;
  assign fixed_pattern_correction_mode = ctl_reg.fixed_pattern_noise;
  assign row_blank = ctl_reg.blank;
  assign row_read = ctl_reg.read;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property (psel && !penable |=> pready && !$past(penable))
    else $error("no answer in cycle after setup");
  a_apb_single: assert property (pready |=> !pready)
    else $error("pready held more than one cycle");
  a_analog_split: assert property (!ctl_reg.family |-> sensor_analog_gain <= 16'h0631)
    else $error("analog gain above 15.85 in family one");
  a_sensor_range: assert property (!ctl_reg.family |->
    32'(sensor_analog_gain) * 32'(sensor_digital_gain) <= 32'h0026_4cb0)
    else $error("combined sensor gain above 251");
  a_family_two: assert property (ctl_reg.family && $stable(ctl_reg.family) |=>
    sensor_analog_gain <= 16'h0320 && sensor_digital_gain <= 16'h0c7f)
    else $error("family two gain out of range");
  a_post_range: assert property (ctl_reg.g_post >= 6'h0a && ctl_reg.g_post <= 6'h28)
    else $error("post gain outside 1..4");
  a_offset_range: assert property (ctl_reg.family && psel && penable && pready && pwrite
    && paddr == ADDR_OFFSET |=> ctl_reg.off_sensor <= 9'h0ff && ctl_reg.off_digital <= 9'h0ff)
    else $error("family two offset above 255");
  a_raw_load: assert property (!ctl_reg.family && psel && penable && pready && pwrite
    && paddr == ADDR_RAW && pwdata == 32'h0 |=> ##1 ctl_reg.g_all == 16'h0064)
    else $error("raw code 0 did not give unity gain");
  a_seq_order: assert property ($rose(row_read) && !ctl_reg.blank |-> $past(row_blank))
    else $error("sequential readout began without blanking");
  a_overlap_par: assert property ($rose(row_blank) && $past(ctl_reg.overlap) |-> row_read)
    else $error("overlapped readout not parallel");
  a_pix_latency: assert property (raw_pixel_valid |-> ##2 image_valid)
    else $error("pixel lost in path");
  a_fpn_follow: assert property (psel && penable && pready && pwrite && paddr == ADDR_CTRL
    |=> fixed_pattern_correction_mode == $past(pwdata[CTRL_FPN_BIT]))
    else $error("correction mode not taken");
  c_overlap_row: cover property (ctl_reg.rd == RD_BOTH ##1 ctl_reg.rd == RD_IDLE);
  c_raw_write: cover property (ctl_reg.raw_load ##1 ctl_reg.raw_mode);
  c_digital_split: cover property (sensor_digital_gain > 16'h0064 && !ctl_reg.family);
  c_pixel_full: cover property (image_valid && image_data == {PW{1'b1}});
endmodule

//--- logic/pixel_gain_path.sv
// Two-stage pixel pipeline: post-sensor gain, dark offset, saturation
`timescale 1ns/1ps
module pixel_gain_path
  import gain_offset_pkg::*;
#(
  parameter int PW = 12
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pixel in and settings
  input wire logic in_valid,
  input wire logic [PW-1:0] in_data,
  input wire logic [5:0] gain_x10,
  input wire logic [8:0] offset,
  // Pixel out
  output logic out_valid,
  output logic [PW-1:0] out_data
);
  typedef struct packed {
    logic v1;
    logic [PW+5:0] prod;
    logic [8:0] off;
    logic v2;
    logic [PW-1:0] data;
  } path_t;
  path_t path_reg;
  path_t path_next;
  localparam logic [PW+3:0] PIX_MAX = {4'h0, {PW{1'b1}}};
  always_comb
  begin
    logic [PW+19:0] scaled;
    logic [PW+3:0] sum;
    path_next = path_reg;
    path_next.v1 = in_valid;
    path_next.prod = (PW+6)'(in_data) * (PW+6)'(gain_x10);
    path_next.off = offset;
    scaled = ((PW+20)'(path_reg.prod) * (PW+20)'(RECIP_TEN)) >> 16;
    sum = scaled[PW+3:0] + (PW+4)'(path_reg.off);
    path_next.v2 = path_reg.v1;
    // clip at full scale, a wrapped bright pixel would turn black
    path_next.data = (sum > PIX_MAX) ? PIX_MAX[PW-1:0] : sum[PW-1:0];
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      path_reg <= '0;
    else
      path_reg <= path_next;
  end
  assign out_valid = path_reg.v2;
  assign out_data = path_reg.data;
  a_path_sat: assert property (@(posedge clk) disable iff (!rst_n)
    path_reg.v1 && ((path_reg.prod / 10) + path_reg.off) > (PW+6)'(PIX_MAX)
    |=> out_data == PIX_MAX[PW-1:0])
    else $error("pixel wrapped instead of saturating");
endmodule

//--- tb/sensor_pixel_model.sv
// Behavioural image sensor that streams raw pixels into the block
`timescale 1ns/1ps
module sensor_pixel_model
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stream command
  input wire logic start,
  input wire logic [11:0] first,
  input wire logic [11:0] step,
  input wire logic [7:0] count,
  input wire logic [1:0] gap,
  output logic busy,
  // Raw pixels
  output logic pix_valid,
  output logic [11:0] pix_data
);
  logic [7:0] left_reg;
  logic [1:0] wait_reg;
  logic [11:0] next_reg;

  assign busy = (left_reg != 8'h00);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left_reg <= 8'h00;
      wait_reg <= 2'h0;
      next_reg <= 12'h000;
      pix_valid <= 1'b0;
      pix_data <= 12'h000;
    end
    else
    begin
      pix_valid <= 1'b0;
      // Idle data toggles so a stale value never passes for a pixel
      pix_data <= ~pix_data;
      if (start && !busy)
      begin
        left_reg <= count;
        next_reg <= first;
        wait_reg <= 2'h0;
      end
      else if (busy && wait_reg == 2'h0)
      begin
        pix_valid <= 1'b1;
        pix_data <= next_reg;
        next_reg <= next_reg + step;
        left_reg <= left_reg - 8'h01;
        wait_reg <= gap;
      end
      else if (wait_reg != 2'h0)
        wait_reg <= wait_reg - 2'h1;
    end
  end
endmodule

//--- tb/testbench.sv
// Testbench: APB registers, pixel path and row sequencer of the gain/offset block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %0h got %0h", nm, (e), (g)); end end
module testbench;
  import gain_offset_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic raw_pixel_valid;
  logic [11:0] raw_pixel_data;
  logic row_request = 1'b0;
  logic image_valid;
  logic [11:0] image_data;
  logic [15:0] sensor_analog_gain;
  logic [15:0] sensor_digital_gain;
  logic [8:0] sensor_dark_offset;
  logic overlapped_row_readout;
  logic fixed_pattern_correction_mode;
  logic row_blank;
  logic row_read;
  logic start = 1'b0;
  logic [11:0] first = 12'h000;
  logic [11:0] step = 12'h000;
  logic [7:0] count = 8'h00;
  logic [1:0] gap = 2'h0;
  logic sbusy;
  int err_total = 0;
  int checks_done = 0;
  int g10 = 10;
  int doff = 0;
  logic [31:0] rd_data;
  logic rd_err;
  logic [1:0] vpipe = 2'h0;
  logic [11:0] e_pix;
  logic [11:0] expq[$];

  always #20 pclk = ~pclk;

  // Short row counts keep the sequencer checks brief
  pixel_gain_offset_control #(.PW(12), .BLANK_CYCLES(2), .READ_CYCLES(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .raw_pixel_valid(raw_pixel_valid), .raw_pixel_data(raw_pixel_data),
    .row_request(row_request), .image_valid(image_valid), .image_data(image_data),
    .sensor_analog_gain(sensor_analog_gain), .sensor_digital_gain(sensor_digital_gain),
    .sensor_dark_offset(sensor_dark_offset), .overlapped_row_readout(overlapped_row_readout),
    .fixed_pattern_correction_mode(fixed_pattern_correction_mode),
    .row_blank(row_blank), .row_read(row_read));

  sensor_pixel_model sensor (.pclk(pclk), .presetn(presetn), .start(start), .first(first),
    .step(step), .count(count), .gap(gap), .busy(sbusy), .pix_valid(raw_pixel_valid),
    .pix_data(raw_pixel_data));

  task automatic print_verdict;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      err_total++;
      print_verdict();
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd_data)
  endtask

  task automatic settle;
    repeat (4) @(posedge pclk);
    #1;
  endtask

  task automatic run_row(input logic ovl);
    @(posedge pclk);
    row_request <= 1'b1;
    @(posedge pclk);
    row_request <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      #1;
      `CHK("row_blank", (i < 2), row_blank)
      `CHK("row_read", ovl ? (i < 4) : (i >= 2 && i < 6), row_read)
      @(posedge pclk);
      // A request while busy must be dropped
      row_request <= (i == 1);
    end
  endtask

  task automatic stream(input logic [11:0] f, input logic [11:0] s, input logic [7:0] c,
                        input logic [1:0] gp);
    int n;
    n = 0;
    @(posedge pclk);
    start <= 1'b1;
    first <= f;
    step <= s;
    count <= c;
    gap <= gp;
    @(posedge pclk);
    start <= 1'b0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((sbusy === 1'b1 || n < 2) && n < 200);
    if (n >= 200)
    begin
      err_total++;
      print_verdict();
    end
    repeat (4) @(posedge pclk);
    `CHK("pending", 0, expq.size())
  endtask

  function automatic logic [11:0] exp_pix(input logic [11:0] v);
    longint p;
    p = ((longint'(v) * g10 * RECIP_TEN) >> 16) + doff;
    return (p > 64'h0fff) ? 12'hfff : p[11:0];
  endfunction

  // Latency and value of every pixel leaving the path
  always @(posedge pclk)
  begin
    if (presetn)
    begin
      if (vpipe[1] || image_valid !== 1'b0)
        `CHK("image_valid", vpipe[1], image_valid)
      if (image_valid === 1'b1 && expq.size() > 0)
      begin
        e_pix = expq.pop_front();
        `CHK("image_data", e_pix, image_data)
      end
      vpipe <= {vpipe[0], raw_pixel_valid};
      if (raw_pixel_valid === 1'b1)
        expq.push_back(exp_pix(raw_pixel_data));
    end
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_SENSOR, 32'h0064_0064, "sensor_rst");
    rd(ADDR_STATUS, 32'h0, "status_rst");
    wr(ADDR_GAIN, 32'h7d0);
    settle();
    `CHK("analog", A_ANALOG_MAX[15:0], sensor_analog_gain)
    `CHK("digital", 16'h007e, sensor_digital_gain)
    rd(ADDR_GAIN, 32'h7d0, "gain");
    wr(ADDR_GAIN, 32'h7530);
    rd(ADDR_GAIN, A_ALL_MAX, "gain_hi");
    rd(ADDR_SENSOR, 32'h062f_0631, "sensor_hi");
    wr(ADDR_GAIN, 32'h32);
    rd(ADDR_GAIN, GAIN_MIN, "gain_lo");
    wr(ADDR_GAIN, 32'h3e8);
    settle();
    `CHK("analog_1k", 16'h03e8, sensor_analog_gain)
    `CHK("digital_1k", 16'h0064, sensor_digital_gain)
    wr(ADDR_RAW, 32'h258);
    settle();
    rd(ADDR_GAIN, A_ALL_MAX, "raw_max");
    rd(ADDR_STATUS, 32'h8, "raw_mode");
    wr(ADDR_RAW, 32'h0);
    settle();
    rd(ADDR_GAIN, GAIN_MIN, "raw_zero");
    wr(ADDR_CTRL, 32'h18);
    settle();
    `CHK("overlap", 1'b1, overlapped_row_readout)
    `CHK("fpn_on", 1'b1, fixed_pattern_correction_mode)
    run_row(1'b1);
    wr(ADDR_CTRL, 32'h0);
    settle();
    `CHK("fpn_off", 1'b0, fixed_pattern_correction_mode)
    run_row(1'b0);
    wr(ADDR_CTRL, 32'h21);
    wr(ADDR_GAIN, 32'h3e8);
    rd(ADDR_GAIN, B_ANALOG_MAX, "b_analog");
    wr(ADDR_CTRL, 32'h22);
    wr(ADDR_GAIN, 32'h1388);
    rd(ADDR_GAIN, B_DIGITAL_MAX, "b_digital");
    rd(ADDR_RAW, B_DIGITAL_MAX, "b_raw");
    wr(ADDR_RAW, 32'h5dc);
    rd(ADDR_GAIN, 32'h5dc, "b_raw_wr");
    wr(ADDR_OFFSET, 32'h12c);
    settle();
    `CHK("b_ofs_pin", 9'h0ff, sensor_dark_offset)
    rd(ADDR_OFFSET, OFFSET_B_MAX, "b_ofs");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_OFFSET, 32'h258);
    rd(ADDR_OFFSET, OFFSET_A_MAX, "a_ofs");
    apb(1'b1, 12'h018, 32'h5);
    `CHK("unmapped_err", 1'b1, rd_err)
    rd(12'h018, 32'h0, "unmapped");
    rd(ADDR_OFFSET, OFFSET_A_MAX, "ofs_kept");
    wr(ADDR_CTRL, 32'h7);
    wr(ADDR_GAIN, 32'h32);
    rd(ADDR_GAIN, POST_MAX, "post_hi");
    wr(ADDR_OFFSET, 32'h64);
    g10 = 40;
    doff = 100;
    // First two pixels stay below full scale so the offset is visible
    stream(12'h064, 12'h1f4, 8'h07, 2'h0);
    wr(ADDR_GAIN, 32'h5);
    rd(ADDR_GAIN, POST_MIN, "post_lo");
    wr(ADDR_GAIN, 32'hf);
    wr(ADDR_OFFSET, 32'h0);
    g10 = 15;
    doff = 0;
    stream(12'hfff, 12'hf00, 8'h05, 2'h2);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_OFFSET, 32'hc8);
    settle();
    `CHK("ofs_pin", 9'h0c8, sensor_dark_offset)
    stream(12'h064, 12'h100, 8'h03, 2'h1);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_GAIN, GAIN_MIN, "stage_kept");
    print_verdict();
  end
endmodule
